// ### bench/t2crb_far_model.sv
// far side of the timer: count and trigger pins, timer1 pulses, uart clock tallies
`timescale 1ns/1ps
module t2crb_far_model
(
    // clock
    input wire logic hclk,
    // timer outputs seen by the far side
    input wire logic uart_tx_clock,
    input wire logic uart_rx_clock,
    input wire logic clk_pin,
    // levels driven by the far side
    output logic count_drv,
    output logic trig_drv,
    output logic t1_ovf
);
    int tx_n = 0;
    int rx_n = 0;
    int pin_n = 0;
    int t1_div = 0;
    logic t1_on = 1'b0;
    logic pin_last = 1'b0;
    // pins idle high so that only falls are events
    initial
    begin
        count_drv = 1'b1;
        trig_drv = 1'b1;
        t1_ovf = 1'b0;
    end
    // timer1 pulse every 8 cycles, and tallies of what the timer sends
    always @(posedge hclk)
    begin
        t1_div <= (t1_div == 7) ? 0 : t1_div + 1;
        t1_ovf <= t1_on && (t1_div == 7);
        tx_n <= tx_n + int'(uart_tx_clock);
        rx_n <= rx_n + int'(uart_rx_clock);
        pin_n <= pin_n + int'(clk_pin != pin_last);
        pin_last <= clk_pin;
    end
    // falling pulses, six cycles low and six high, within the pin rate limit
    task automatic pulse(input bit trig, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge hclk);
            if (trig) trig_drv <= 1'b0; else count_drv <= 1'b0;
            repeat (6) @(posedge hclk);
            if (trig) trig_drv <= 1'b1; else count_drv <= 1'b1;
            repeat (5) @(posedge hclk);
        end
    endtask : pulse
endmodule : t2crb_far_model

// ### bench/t2crb_timer_monitor.sv
// checker of bus timing, uart clock routing, pin enable and interrupt mask of the timer
`timescale 1ns/1ps
module t2crb_timer_monitor
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [9:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins, uart clocks and interrupt
    input wire logic count_clock_pin_o,
    input wire logic count_clock_pin_oe,
    input wire logic timer1_overflow,
    input wire logic uart_rx_clock,
    input wire logic uart_tx_clock,
    input wire logic timer_irq
);
    import t2crb_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic acc;
    logic clk_mode;
    logic wr_q;
    logic rd_q;
    logic [7:0] idx_q;
    logic [5:0] ctl_q;
    logic oe_q;
    logic ien_q;
    // transfer taken, and clock-out mode decoded from the shadow bits
    assign acc = hsel & hready & htrans[1];
    assign clk_mode = ctl_q[B_RUN] & ~ctl_q[B_RCLK] & ~ctl_q[B_UART_TX_CLOCK_SELECT] & ~ctl_q[B_CPRL] & oe_q;
    // data phase tracking
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc & hwrite & (haddr[1:0] == 2'b00);
            rd_q <= acc & ~hwrite;
            idx_q <= haddr[9:2];
        end
    end
    // shadow of the bits that only software changes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl_q <= 6'h00;
            oe_q <= 1'b0;
            ien_q <= 1'b0;
        end
        else if (wr_q)
        begin
            case (idx_q)
                IDX_CONTROL: ctl_q <= hwdata[5:0];
                IDX_CTRL_SET: ctl_q <= ctl_q | hwdata[5:0];
                IDX_CTRL_CLR: ctl_q <= ctl_q & ~hwdata[5:0];
                IDX_MODE: oe_q <= hwdata[B_OE];
                IDX_IRQ_EN: ien_q <= hwdata[0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    read_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");
    write_ready_a: assert property (acc && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    hrdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_q))
        else $error("read data changed outside a read");
    clkout_idle_a: assert property (!count_clock_pin_oe && !$past(count_clock_pin_oe)
        |-> $stable(count_clock_pin_o))
        else $error("clock-out pin moved while not enabled");
    pin_enable_a: assert property (clk_mode == $past(clk_mode) && clk_mode == $past(clk_mode, 2)
        |-> count_clock_pin_oe == clk_mode)
        else $error("pin enable disagrees with clock-out mode");
    tx_route_a: assert property (!ctl_q[B_UART_TX_CLOCK_SELECT] |=> uart_tx_clock == $past(timer1_overflow))
        else $error("transmit clock not taken from timer1");
    rx_route_a: assert property (!ctl_q[B_RCLK] |=> uart_rx_clock == $past(timer1_overflow))
        else $error("receive clock not taken from timer1");
    irq_mask_a: assert property (!ien_q && !$past(ien_q) |-> !timer_irq)
        else $error("interrupt raised while disabled");
    cover property (count_clock_pin_oe && $changed(count_clock_pin_o));
    cover property (uart_tx_clock && ctl_q[B_UART_TX_CLOCK_SELECT]);
    cover property (timer_irq);
endmodule : t2crb_timer_monitor

bind t2crb_timer t2crb_timer_monitor t2crb_timer_monitor_i
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .count_clock_pin_o, .count_clock_pin_oe, .timer1_overflow,
    .uart_rx_clock, .uart_tx_clock, .timer_irq
);

// ### bench/tb_top.sv
// register-level tests of the capture/reload/baud timer
`timescale 1ns/1ps
module tb_top;
    import t2crb_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [9:0] haddr = 10'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin_o;
    logic pin_oe;
    logic cnt_drv;
    logic trig;
    logic t1;
    logic rxc;
    logic txc;
    logic irq;
    wire logic cnt_pin = pin_oe ? pin_o : cnt_drv;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] v;
    int b1;
    int b2;
    // clock, 50 ns period
    always #25 hclk = ~hclk;
    t2crb_timer t2crb_timer_i
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_clock_pin_i(cnt_pin), .count_clock_pin_o(pin_o),
        .count_clock_pin_oe(pin_oe), .trigger_pin_i(trig), .timer1_overflow(t1),
        .uart_rx_clock(rxc), .uart_tx_clock(txc), .timer_irq(irq)
    );
    t2crb_far_model t2crb_far_model_i
    (
        .hclk(hclk), .uart_tx_clock(txc), .uart_rx_clock(rxc), .clk_pin(pin_o),
        .count_drv(cnt_drv), .trig_drv(trig), .t1_ovf(t1)
    );
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        htrans <= 2'b10;
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(v, {24'h0, exp});
    endtask : rdc
    task automatic wr16(input logic [7:0] idx, input logic [15:0] d);
        wr(idx, d[7:0]);
        wr(idx + 8'h01, d[15:8]);
    endtask : wr16
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // hang guard
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, individual bit access, unmapped place
        rdc(IDX_CONTROL, 8'h00);
        rdc(IDX_MODE, 8'h00);
        rdc(IDX_CAP_LOW, 8'h00);
        rdc(IDX_CNT_HIGH, 8'h00);
        rdc(IDX_IRQ_EN, 8'h00);
        wr(IDX_CTRL_SET, 8'h08);
        wr(IDX_CTRL_SET, 8'h01);
        rdc(IDX_CONTROL, 8'h09);
        wr(IDX_CTRL_CLR, 8'h08);
        rdc(IDX_CONTROL, 8'h01);
        wr(8'hD7, 8'h5A);
        rdc(8'hD7, 8'h00);
        wr(IDX_MODE, 8'h03);
        rdc(IDX_MODE, 8'h03);
        wr(IDX_MODE, 8'h00);
        $display("test registers done");
        // stopped, machine-cycle rate, oscillator rate in baud mode, pin events
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CNT_LOW, 8'h10);
        repeat (40) @(posedge hclk);
        rdc(IDX_CNT_LOW, 8'h10);
        wr(IDX_CONTROL, 8'h04);
        repeat (60) @(posedge hclk);
        wr(IDX_CONTROL, 8'h00);
        bus(1'b0, IDX_CNT_LOW, 8'h00);
        check(v >= 32'h19 && v <= 32'h1B, 1);
        wr(IDX_CNT_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h14);
        repeat (60) @(posedge hclk);
        wr(IDX_CONTROL, 8'h00);
        bus(1'b0, IDX_CNT_LOW, 8'h00);
        check(v >= 32'd61 && v <= 32'd65, 1);
        wr(IDX_CNT_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h06);
        t2crb_far_model_i.pulse(1'b0, 5);
        rdc(IDX_CNT_LOW, 8'h05);
        $display("test rates done");
        // overflow reloads capture value, flag and interrupt
        wr(IDX_CONTROL, 8'h00);
        wr16(IDX_CAP_LOW, 16'h1234);
        wr16(IDX_CNT_LOW, 16'hFFFE);
        wr(IDX_CONTROL, 8'h06);
        t2crb_far_model_i.pulse(1'b0, 2);
        rdc(IDX_CONTROL, 8'h86);
        rdc(IDX_CNT_LOW, 8'h34);
        rdc(IDX_CNT_HIGH, 8'h12);
        check(irq, 1'b0);
        wr(IDX_IRQ_EN, 8'h01);
        repeat (2) @(posedge hclk);
        check(irq, 1'b1);
        wr(IDX_CTRL_CLR, 8'h80);
        rdc(IDX_CONTROL, 8'h06);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        $display("test overflow done");
        // capture, reload on trigger, trigger ignored
        wr(IDX_CONTROL, 8'h00);
        wr16(IDX_CNT_LOW, 16'h00AB);
        wr(IDX_CONTROL, 8'h0F);
        t2crb_far_model_i.pulse(1'b1, 1);
        rdc(IDX_CAP_LOW, 8'hAB);
        rdc(IDX_CAP_HIGH, 8'h00);
        rdc(IDX_CONTROL, 8'h4F);
        repeat (2) @(posedge hclk);
        check(irq, 1'b1);
        t2crb_far_model_i.pulse(1'b0, 1);
        rdc(IDX_CNT_LOW, 8'hAC);
        wr(IDX_CONTROL, 8'h0E);
        t2crb_far_model_i.pulse(1'b1, 1);
        rdc(IDX_CNT_LOW, 8'hAB);
        rdc(IDX_CONTROL, 8'h4E);
        wr(IDX_CONTROL, 8'h06);
        wr(IDX_CNT_LOW, 8'h50);
        t2crb_far_model_i.pulse(1'b1, 1);
        rdc(IDX_CNT_LOW, 8'h50);
        rdc(IDX_CONTROL, 8'h06);
        wr(IDX_IRQ_EN, 8'h00);
        $display("test capture done");
        // down counting to the capture value
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MODE, 8'h01);
        wr16(IDX_CNT_LOW, 16'h00AD);
        t2crb_far_model_i.trig_drv <= 1'b0;
        wr(IDX_CONTROL, 8'h06);
        t2crb_far_model_i.pulse(1'b0, 3);
        rdc(IDX_CNT_LOW, 8'hFF);
        rdc(IDX_CNT_HIGH, 8'hFF);
        rdc(IDX_CONTROL, 8'hC6);
        t2crb_far_model_i.trig_drv <= 1'b1;
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MODE, 8'h00);
        $display("test down done");
        // baud mode drives both uart clocks, no overflow flag, forced reload
        wr16(IDX_CAP_LOW, 16'hFFF0);
        wr16(IDX_CNT_LOW, 16'hFFF0);
        t2crb_far_model_i.t1_on <= 1'b1;
        wr(IDX_CONTROL, 8'h35);
        b1 = t2crb_far_model_i.tx_n;
        b2 = t2crb_far_model_i.rx_n;
        repeat (200) @(posedge hclk);
        b1 = t2crb_far_model_i.tx_n - b1;
        b2 = t2crb_far_model_i.rx_n - b2;
        check(b1 >= 11 && b1 <= 14, 1);
        check(b2 >= 11 && b2 <= 14, 1);
        rdc(IDX_CONTROL, 8'h35);
        wr(IDX_CONTROL, 8'h00);
        rdc(IDX_CNT_HIGH, 8'hFF);
        b1 = t2crb_far_model_i.tx_n;
        repeat (80) @(posedge hclk);
        b1 = t2crb_far_model_i.tx_n - b1;
        check(b1 >= 9 && b1 <= 11, 1);
        t2crb_far_model_i.t1_on <= 1'b0;
        $display("test baud done");
        // clock-out square wave without overflow flag
        wr(IDX_MODE, 8'h02);
        wr16(IDX_CNT_LOW, 16'hFFFE);
        wr16(IDX_CAP_LOW, 16'hFFFE);
        wr(IDX_CONTROL, 8'h04);
        b1 = t2crb_far_model_i.pin_n;
        repeat (300) @(posedge hclk);
        check(pin_oe, 1'b1);
        check(t2crb_far_model_i.pin_n - b1 >= 2, 1);
        rdc(IDX_CONTROL, 8'h04);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MODE, 8'h00);
        repeat (3) @(posedge hclk);
        check(pin_oe, 1'b0);
        $display("test clock-out done");
        wrap_up();
    end
endmodule : tb_top

// ### hdl/t2crb_pkg.sv
// constants, register map and mode codes of the capture/reload/baud timer
//
// Contract
// R1: one 16-bit counter, timer or event counter
// R2: mode from run, uart selects, capture, output
// R3: timer ticks fosc/6, counter counts pin falls
// R4: overflow sets overflow_flag, bit 7, sticky
// R5: no overflow_flag in uart or clock-out modes
// R6: trigger fall sets external_event_flag when enabled; here not in clock-out mode or while down counting
// R7: interrupt requested while external_event_flag set, enabled
// R8: rx select bit 5 routes our overflows
// R9: tx select bit 4 routes our overflows
// R10: trigger enable bit 3 gates capture/reload events
// R11: run_control bit 2 starts and stops counting
// R12: select bit 0 picks capture or reload
// R13: uart clocking forces reload on overflow
// R14: clock_out_enable bit 1 acts in clock-out only
// R15: down_count_enable bit 0 allows up/down counting
// R16: software writes zero to mode bits 7..2
// R17: control clears on reset, bits individually settable
// R18: capture copies counter bytes, counting continues
// R19: up overflow sets flag, reloads capture value
// R20: down counts to capture value, reloads all ones
// R21: baud mode increments every oscillator clock
// R22: clock-out toggles pin on every rollover
package t2crb_pkg;
    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_MODE = 8'hC9;
    localparam logic [7:0] IDX_CAP_LOW = 8'hCA;
    localparam logic [7:0] IDX_CAP_HIGH = 8'hCB;
    localparam logic [7:0] IDX_CNT_LOW = 8'hCC;
    localparam logic [7:0] IDX_CNT_HIGH = 8'hCD;
    localparam logic [7:0] IDX_CTRL_SET = 8'hCE;
    localparam logic [7:0] IDX_CTRL_CLR = 8'hCF;
    localparam logic [7:0] IDX_IRQ_EN = 8'hD0;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int B_OVF = 7;
    localparam int B_EXF = 6;
    localparam int B_RCLK = 5;
    localparam int B_UART_TX_CLOCK_SELECT = 4;
    localparam int B_EXEN = 3;
    localparam int B_RUN = 2;
    localparam int B_CTS = 1;
    localparam int B_CPRL = 0;
    // mode register fields
    localparam int B_OE = 1;
    localparam int B_DOWN_COUNT_ENABLE = 0;
    localparam logic [7:0] MODE_MASK = 8'h03;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [2:0] PRESC_LAST = 3'h5; // fosc/6 machine cycle
    typedef enum logic [2:0]
    {
        T2CRB_OFF = 3'b000,
        T2CRB_RELOAD = 3'b001,
        T2CRB_CAPTURE = 3'b010,
        T2CRB_CLKOUT = 3'b011,
        T2CRB_BAUD = 3'b100
    } t2crb_mode_e;
endpackage : t2crb_pkg

// ### hdl/t2crb_timer.sv
// capture/reload/baud timer with its ahb-lite register slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// three-flop pin synchroniser with agreement filter
// ----------------------------------------------------------------
module t2crb_sync
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pin and filtered level
    input wire logic pin_i,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // shift chain, level follows once stage two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                level_q <= s3_q;
            end
        end
    end
endmodule : t2crb_sync

// ----------------------------------------------------------------
// timer top
// ----------------------------------------------------------------
module t2crb_timer
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [9:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins
    input wire logic count_clock_pin_i,
    output logic count_clock_pin_o,
    output logic count_clock_pin_oe,
    input wire logic trigger_pin_i,
    // uart clocks and interrupt
    input wire logic timer1_overflow,
    output logic uart_rx_clock,
    output logic uart_tx_clock,
    output logic timer_irq
);
    import t2crb_pkg::*;

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] mode_q;
    logic irq_en_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cap_q;
    logic [15:0] cap_d;
    logic [2:0] presc_q;
    logic cnt_lvl;
    logic trg_lvl;
    logic cnt_lvl_q;
    logic trg_lvl_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] idx_q;
    logic [31:0] rdata;
    logic [7:0] wd;
    logic wr_ctrl;
    logic tick;
    logic trg_fall;
    logic set_ovf;
    logic set_exf;
    logic tog_exf;
    logic ovf_pulse;
    logic pin_tog;
    logic uart_sel;
    t2crb_mode_e mode;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    t2crb_sync u_cnt_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_i(count_clock_pin_i),
        .level_q(cnt_lvl)
    );

    t2crb_sync u_trg_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_i(trigger_pin_i),
        .level_q(trg_lvl)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // uart clock select overrides capture and output enable
    assign uart_sel = ctrl_q[B_RCLK] | ctrl_q[B_UART_TX_CLOCK_SELECT];
    always_comb
    begin
        if (!ctrl_q[B_RUN])
            mode = T2CRB_OFF; // R2 R11
        else if (uart_sel)
            mode = T2CRB_BAUD; // R2 R13
        else if (ctrl_q[B_CPRL])
            mode = T2CRB_CAPTURE; // R2 R12
        else if (mode_q[B_OE])
            mode = T2CRB_CLKOUT; // R2 R14
        else
            mode = T2CRB_RELOAD; // R2
    end

    // previous filtered pin levels for edge detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_lvl_q <= 1'b1;
            trg_lvl_q <= 1'b1;
        end
        else
        begin
            cnt_lvl_q <= cnt_lvl;
            trg_lvl_q <= trg_lvl;
        end
    end

    // machine-cycle prescaler, idle while stopped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            presc_q <= 3'h0;
        end
        else if (mode == T2CRB_OFF || presc_q == PRESC_LAST)
        begin
            presc_q <= 3'h0;
        end
        else
        begin
            presc_q <= presc_q + 3'h1; // R3
        end
    end

    // count source: pin falls, oscillator in baud mode, else fosc/6
    always_comb
    begin
        tick = 1'b0;
        if (mode != T2CRB_OFF) // R11
        begin
            if (ctrl_q[B_CTS])
            begin
                tick = cnt_lvl_q & ~cnt_lvl; // R1 R3
            end
            else if (mode == T2CRB_BAUD)
            begin
                tick = 1'b1; // R21
            end
            else
            begin
                tick = (presc_q == PRESC_LAST); // R3
            end
        end
    end

    // trigger falling edge, honoured only when enabled
    assign trg_fall = trg_lvl_q & ~trg_lvl & ctrl_q[B_EXEN]; // R10

    // ------------------------------------------------------------
    // counter, capture and event generation
    // ------------------------------------------------------------
    always_comb
    begin
        cnt_d = cnt_q;
        cap_d = cap_q;
        set_ovf = 1'b0;
        set_exf = 1'b0;
        tog_exf = 1'b0;
        ovf_pulse = 1'b0;
        pin_tog = 1'b0;
        if (tick && mode == T2CRB_CAPTURE)
        begin
            cnt_d = cnt_q + 16'h0001; // R1
            set_ovf = (cnt_q == CNT_MAX); // R4
        end
        else if (tick && mode == T2CRB_RELOAD && mode_q[B_DOWN_COUNT_ENABLE] && !trg_lvl) // R15
        begin
            // down counting ends at the capture value
            cnt_d = (cnt_q == cap_q) ? CNT_MAX : cnt_q - 16'h0001; // R20
            set_ovf = (cnt_q == cap_q); // R20
            tog_exf = (cnt_q == cap_q); // R20
        end
        else if (tick)
        begin
            // up counting reloads at rollover; no flag in baud or clock-out
            cnt_d = (cnt_q == CNT_MAX) ? cap_q : cnt_q + 16'h0001; // R19 R13
            set_ovf = (cnt_q == CNT_MAX) && mode == T2CRB_RELOAD; // R4 R5 R19
            tog_exf = (cnt_q == CNT_MAX) && mode == T2CRB_RELOAD && mode_q[B_DOWN_COUNT_ENABLE]; // R20
            pin_tog = (cnt_q == CNT_MAX) && mode == T2CRB_CLKOUT; // R22
            ovf_pulse = (cnt_q == CNT_MAX) && mode == T2CRB_BAUD; // R8 R9
        end
        // trigger events; down counting uses the pin as direction instead
        if (trg_fall && mode == T2CRB_CAPTURE)
            cap_d = cnt_q; // R18
        if (trg_fall && mode == T2CRB_RELOAD && !mode_q[B_DOWN_COUNT_ENABLE])
            cnt_d = cap_q; // R12
        set_exf = trg_fall && (mode == T2CRB_CAPTURE || mode == T2CRB_BAUD
            || (mode == T2CRB_RELOAD && !mode_q[B_DOWN_COUNT_ENABLE])); // R6 R10
        // software writes: counter write wins, capture event wins
        if (wr_q && idx_q == IDX_CNT_LOW)
            cnt_d[7:0] = wd;
        if (wr_q && idx_q == IDX_CNT_HIGH)
            cnt_d[15:8] = wd;
        if (wr_q && idx_q == IDX_CAP_LOW && !(trg_fall && mode == T2CRB_CAPTURE))
            cap_d[7:0] = wd;
        if (wr_q && idx_q == IDX_CAP_HIGH && !(trg_fall && mode == T2CRB_CAPTURE))
            cap_d[15:8] = wd;
    end

    // counter and capture registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= CNT_ZERO;
            cap_q <= CNT_ZERO;
        end
        else
        begin
            cnt_q <= cnt_d;
            cap_q <= cap_d;
        end
    end

    // ------------------------------------------------------------
    // control register: whole write, bit set, bit clear, hw flags
    // ------------------------------------------------------------
    assign wd = hwdata[7:0];
    assign wr_ctrl = wr_q && idx_q == IDX_CONTROL;
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
            ctrl_d = wd;
        if (wr_q && idx_q == IDX_CTRL_SET)
            ctrl_d = ctrl_q | wd; // R17
        if (wr_q && idx_q == IDX_CTRL_CLR)
            ctrl_d = ctrl_q & ~wd; // R17
        // hardware sets win over a clear in the same cycle
        if (set_ovf)
            ctrl_d[B_OVF] = 1'b1; // R4
        if (set_exf)
            ctrl_d[B_EXF] = 1'b1; // R6
        if (tog_exf)
            ctrl_d[B_EXF] = ~ctrl_q[B_EXF]; // R20
    end

    // control, mode and interrupt enable registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= CTRL_RESET; // R17
            mode_q <= MODE_RESET;
            irq_en_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (wr_q && idx_q == IDX_MODE)
            begin
                mode_q <= wd & MODE_MASK; // R14 R15 R16
            end
            if (wr_q && idx_q == IDX_IRQ_EN)
            begin
                irq_en_q <= wd[0];
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs: uart clocks, clock-out pin, interrupt
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uart_rx_clock <= 1'b0;
            uart_tx_clock <= 1'b0;
            count_clock_pin_o <= 1'b0;
            count_clock_pin_oe <= 1'b0;
            timer_irq <= 1'b0;
        end
        else
        begin
            uart_rx_clock <= ctrl_q[B_RCLK] ? ovf_pulse : timer1_overflow; // R8
            uart_tx_clock <= ctrl_q[B_UART_TX_CLOCK_SELECT] ? ovf_pulse : timer1_overflow; // R9
            count_clock_pin_oe <= (mode == T2CRB_CLKOUT); // R14
            if (pin_tog)
            begin
                count_clock_pin_o <= ~count_clock_pin_o; // R22
            end
            timer_irq <= irq_en_q & (ctrl_q[B_OVF] | ctrl_q[B_EXF]); // R7
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (idx_q)
            IDX_CONTROL: rdata[7:0] = ctrl_q;
            IDX_MODE: rdata[7:0] = mode_q;
            IDX_CAP_LOW: rdata[7:0] = cap_q[7:0];
            IDX_CAP_HIGH: rdata[7:0] = cap_q[15:8];
            IDX_CNT_LOW: rdata[7:0] = cnt_q[7:0];
            IDX_CNT_HIGH: rdata[7:0] = cnt_q[15:8];
            IDX_IRQ_EN: rdata[0] = irq_en_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // address phase capture and data phase completion
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            wr_q <= 1'b0;
            if (rd_q)
            begin
                rd_q <= 1'b0;
                hrdata <= rdata;
                hreadyout <= 1'b1;
            end
            else if (hsel && hready && htrans[1])
            begin
                idx_q <= (haddr[9:2] != 8'h00 && haddr[1:0] == 2'b00) ? haddr[9:2] : 8'h00;
                wr_q <= hwrite;
                rd_q <= ~hwrite;
                hreadyout <= hwrite;
            end
        end
    end
endmodule : t2crb_timer
